// ### rtl/pinmux_cfg.svh
// Register map, field positions, reset values and timing counts
`ifndef PINMUX_CFG_SVH
`define PINMUX_CFG_SVH
`define OFS_IRQ_RAW     8'h00
`define OFS_IRQ_MASKED  8'h04
`define OFS_IRQ_ENABLE  8'h08
`define OFS_IRQ_EN_SET  8'h0c
`define OFS_IRQ_EN_CLR  8'h10
`define OFS_SEL_OUT0    8'h14
`define OFS_SEL_OUT1    8'h18
`define OFS_SEL_OUT2    8'h1c
`define OFS_SEL_OUT3    8'h20
`define OFS_CLKREC_CTRL 8'h24
`define OFS_GPO         8'h28
`define OFS_PROG_IN     8'h2c
`define OFS_IF_MODE     8'h30
`define OFS_CODE_BYP    8'h34
`define OFS_CLK_TAP     8'h38
`define IF_MODE_MAC_BIT 0
`define IF_MODE_RF_BIT  1
`define SEL_SRC_LSB     0
`define SEL_IDX_LSB     4
`define RST_SEL         8'h00
`define RST_GPO         5'h00
`define RST_IF_MODE     2'h0
`define RST_CODE_BYP    6'h00
`define RST_CLK_TAP     3'h0
`define RST_IRQ_EN      16'h0000
`define CLK_PERIOD_NS   10
`define SETTLE_NS       15000
`define SETTLE_CYC      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10
`endif

// ### rtl/pinmux_pkg.sv
// Types shared by the interrupt and pin multiplexer block
package pinmux_pkg;
  typedef enum logic [3:0] {
    SRC_GPO     = 4'h0,
    SRC_IRQ     = 4'h1,
    SRC_CLK     = 4'h2,
    SRC_WAKEUP  = 4'h3,
    SRC_TX_ACT  = 4'h4,
    SRC_TX_ACTN = 4'h5,
    SRC_RX_ACT  = 4'h6,
    SRC_RX_ACTN = 4'h7,
    SRC_RF_TXD  = 4'h8,
    SRC_RF_TXC  = 4'h9,
    SRC_MAC_RXD = 4'ha,
    SRC_MAC_RXC = 4'hb,
    SRC_MIRROR  = 4'hc
  } out_src_e;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RESP = 2'b01
  } bus_state_e;
  typedef struct packed {
    logic tx_if;
    logic tx_radio_stage;
    logic rx_if;
    logic rx_radio_stage;
  } stage_en_s;
  typedef struct packed {
    logic fec_enc;
    logic crc_enc;
    logic whiten;
    logic fec_dec;
    logic crc_chk;
    logic dewhiten;
  } code_byp_s;
endpackage : pinmux_pkg

// ### rtl/irq_and_output_mux.sv
// Interrupt views, programmable output pins, bypass modes and coding bypass
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "pinmux_cfg.svh"

// What this block does
// - Raw, masked and enable registers identify any interrupt source in three reads.
// - Raw, masked and enable views exist; only enabled sources drive the request.
// - Separate set and clear registers change only the written enable bits.
// - Five programmable outputs; four select registers plus clock recovery control.
// - Two mode bits select medium access or radio bypass; medium access wins.
// - Select value zero, the reset value, routes a general output to the pin.
// - Each general output drives the last value written to its bit.
// - General outputs are forced low while the transceiver sleeps.
// - Raw interrupt sources can be selected onto outputs 0, 1, 3 and 4.
// - Output 3 can carry a clock tapped from a ripple counter.
// - Transmit strobe high while both transmit stages enabled; settle 15 us; inverted copy.
// - Receive strobe high while both receive stages enabled; settle 15 us; inverted copy.
// - A base station source carries the wakeup on-off keyed pattern.
// - Output 4 can mirror outputs 0 to 3 or either strobe polarity.
// - Three programmable inputs are readable and feed bypass modes.
// - Medium access bypass skips both datapaths except recovery and correlation.
// - Radio bypass puts modulator data and clock out, converter data from inputs.
// - Transmit encoder, CRC and whitening stages each bypassable by register.
// - Receive decoder, CRC check and dewhitening each bypassable by register.
module irq_and_output_mux #(
  parameter int IRQ_W = 16,
  parameter int CNT_W = 8,
  parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [IRQ_W-1:0]     irq_src,
  input  wire logic                 sleep,
  input  wire pinmux_pkg::stage_en_s stage_en,
  input  wire logic                 wakeup_ook_pattern,
  input  wire logic                 mod_tx_data,
  input  wire logic                 mod_tx_clk,
  input  wire logic                 corr_rx_data,
  input  wire logic                 corr_rx_clk,
  input  wire logic                 prog_in_0,
  input  wire logic                 prog_in_1,
  input  wire logic                 prog_in_2,
  output logic                      prog_out_0,
  output logic                      prog_out_1,
  output logic                      prog_out_2,
  output logic                      prog_out_3,
  output logic                      prog_out_4,
  output logic                      irq_req,
  output logic                      mac_bypass_on,
  output logic                      rf_bypass_on,
  output logic                      bypass_rx_data,
  output logic                      bypass_tx_data,
  output logic                      corr_bypass,
  output pinmux_pkg::code_byp_s     code_byp,
  output logic                      tx_active,
  output logic                      rx_active,
  output logic                      tx_settled,
  output logic                      rx_settled
);

  // Software-visible registers, plus internal counters, input syncs and decodes
  logic [IRQ_W-1:0] irq_en_reg;
  logic [7:0]       sel_reg [0:4];
  logic [4:0]       gpo_reg;
  logic [1:0]       if_mode_reg;
  logic [5:0]       code_byp_reg;
  logic [2:0]       clk_tap_reg;
  logic [CNT_W-1:0] ripple_reg;
  logic [2:0]       pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
  logic [15:0]      tx_cnt_reg, rx_cnt_reg;
  logic [IRQ_W-1:0] irq_masked, en_lane;
  logic             mac_eff, rf_eff, tx_act_now, rx_act_now, clk_tap, pin4_val;
  logic [3:0]       pin_val;

  // Bus handshake state
  pinmux_pkg::bus_state_e wr_state_reg, rd_state_reg;
  logic             aw_have_reg, w_have_reg, wr_fire, wr_hit, rd_hit;
  logic [7:0]       waddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic [31:0]      rd_value;

  // Masked view and mode priority
  assign irq_masked = irq_src & irq_en_reg;
  assign mac_eff    = if_mode_reg[`IF_MODE_MAC_BIT];
  assign rf_eff     = if_mode_reg[`IF_MODE_RF_BIT] & ~mac_eff;
  assign tx_act_now = stage_en.tx_if & stage_en.tx_radio_stage;
  assign rx_act_now = stage_en.rx_if & stage_en.rx_radio_stage;
  assign clk_tap    = ripple_reg[clk_tap_reg];

  // Source picker shared by all five pins; pin restricts irq and clock
  function automatic logic pick(input logic [7:0] sel, input int pin);
    logic [3:0] idx;
    logic       v;
    idx = sel[`SEL_IDX_LSB +: 4];
    v   = 1'b0;
    case (pinmux_pkg::out_src_e'(sel[`SEL_SRC_LSB +: 4]))
      pinmux_pkg::SRC_GPO:     v = gpo_reg[pin] & ~sleep;
      pinmux_pkg::SRC_IRQ:     v = (pin != 2) & irq_src[idx];
      pinmux_pkg::SRC_CLK:     v = (pin == 3) & clk_tap;
      pinmux_pkg::SRC_WAKEUP:  v = wakeup_ook_pattern;
      pinmux_pkg::SRC_TX_ACT:  v = tx_act_now;
      pinmux_pkg::SRC_TX_ACTN: v = ~tx_act_now;
      pinmux_pkg::SRC_RX_ACT:  v = rx_act_now;
      pinmux_pkg::SRC_RX_ACTN: v = ~rx_act_now;
      pinmux_pkg::SRC_RF_TXD:  v = rf_eff & mod_tx_data;
      pinmux_pkg::SRC_RF_TXC:  v = rf_eff & mod_tx_clk;
      pinmux_pkg::SRC_MAC_RXD: v = mac_eff & corr_rx_data;
      pinmux_pkg::SRC_MAC_RXC: v = mac_eff & corr_rx_clk;
      default:                 v = 1'b0;
    endcase
    return v;
  endfunction : pick

  // Pins 0 to 3 from their own selects
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_val[p] = pick(sel_reg[p], p);
    end
  end

  // Pin 4 may mirror another pin rather than pick a source itself
  always_comb begin
    if (sel_reg[4][`SEL_SRC_LSB +: 4] == 4'(pinmux_pkg::SRC_MIRROR)) begin
      pin4_val = pin_val[sel_reg[4][`SEL_IDX_LSB +: 2]];
    end else begin
      pin4_val = pick(sel_reg[4], 4);
    end
  end

  // All pin outputs registered so they never glitch on select changes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {prog_out_4, prog_out_3, prog_out_2, prog_out_1, prog_out_0} <= 5'h00;
    end else begin
      {prog_out_4, prog_out_3, prog_out_2, prog_out_1, prog_out_0} <= {pin4_val, pin_val};
    end
  end

  // Interrupt request from the masked view
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |irq_masked;
    end
  end

  // Free-running counter; its bits are the clock taps
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ripple_reg <= '0;
    end else begin
      ripple_reg <= ripple_reg + 1'b1;
    end
  end

  // Three-stage input sync; value only moves when stages two and three agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg} <= 12'h000;
    end else begin
      pin_s1_reg <= {prog_in_2, prog_in_1, prog_in_0};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // Bypass routing and mode outputs
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {mac_bypass_on, rf_bypass_on, bypass_rx_data, bypass_tx_data, corr_bypass} <= 5'h00;
      code_byp       <= '0;
    end else begin
      mac_bypass_on  <= mac_eff;
      rf_bypass_on   <= rf_eff;
      // Converter data replaced by input 0 only in radio bypass
      bypass_rx_data <= rf_eff & pin_reg[0];
      // Application transmit data enters on input 1 in medium access bypass
      bypass_tx_data <= mac_eff & pin_reg[1];
      // Input 2 lets the application take over correlation itself
      corr_bypass    <= mac_eff & pin_reg[2];
      code_byp       <= pinmux_pkg::code_byp_s'(code_byp_reg);
    end
  end

  // Strobes and their settle counters; drop is immediate on stage disable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {tx_active, rx_active, tx_settled, rx_settled} <= 4'h0;
      tx_cnt_reg <= 16'h0000;
      rx_cnt_reg <= 16'h0000;
    end else begin
      tx_active <= tx_act_now;
      rx_active <= rx_act_now;
      if (!tx_act_now) begin
        tx_cnt_reg <= 16'h0000;
        tx_settled <= 1'b0;
      end else if (tx_cnt_reg < 16'(SETTLE_CYCLES)) begin
        tx_cnt_reg <= tx_cnt_reg + 16'h0001;
      end else begin
        tx_settled <= 1'b1;
      end
      if (!rx_act_now) begin
        rx_cnt_reg <= 16'h0000;
        rx_settled <= 1'b0;
      end else if (rx_cnt_reg < 16'(SETTLE_CYCLES)) begin
        rx_cnt_reg <= rx_cnt_reg + 16'h0001;
      end else begin
        rx_settled <= 1'b1;
      end
    end
  end

  // Write decode: full-word registers, byte strobes on the wide ones
  assign wr_fire = aw_have_reg & w_have_reg & (wr_state_reg == pinmux_pkg::BUS_IDLE);
  assign en_lane = wdata_reg[IRQ_W-1:0] & IRQ_W'({{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}});
  always_comb begin
    case (waddr_reg)
      `OFS_IRQ_EN_SET, `OFS_IRQ_EN_CLR, `OFS_SEL_OUT0, `OFS_SEL_OUT1,
      `OFS_SEL_OUT2, `OFS_SEL_OUT3, `OFS_CLKREC_CTRL, `OFS_GPO,
      `OFS_IF_MODE, `OFS_CODE_BYP, `OFS_CLK_TAP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Enable register: set and clear act only on the written ones
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_reg <= `RST_IRQ_EN;
    end else if (wr_fire && waddr_reg == `OFS_IRQ_EN_SET) begin
      irq_en_reg <= irq_en_reg | en_lane;
    end else if (wr_fire && waddr_reg == `OFS_IRQ_EN_CLR) begin
      irq_en_reg <= irq_en_reg & ~en_lane;
    end
  end

  // Select, value and mode registers, low byte lane only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 5; i++) begin
        sel_reg[i] <= `RST_SEL;
      end
      gpo_reg      <= `RST_GPO;
      if_mode_reg  <= `RST_IF_MODE;
      code_byp_reg <= `RST_CODE_BYP;
      clk_tap_reg  <= `RST_CLK_TAP;
    end else if (wr_fire && wstrb_reg[0]) begin
      case (waddr_reg)
        `OFS_SEL_OUT0:    sel_reg[0]   <= wdata_reg[7:0];
        `OFS_SEL_OUT1:    sel_reg[1]   <= wdata_reg[7:0];
        `OFS_SEL_OUT2:    sel_reg[2]   <= wdata_reg[7:0];
        `OFS_SEL_OUT3:    sel_reg[3]   <= wdata_reg[7:0];
        `OFS_CLKREC_CTRL: sel_reg[4]   <= wdata_reg[7:0];
        `OFS_GPO:         gpo_reg      <= wdata_reg[4:0];
        `OFS_IF_MODE:     if_mode_reg  <= wdata_reg[1:0];
        `OFS_CODE_BYP:    code_byp_reg <= wdata_reg[5:0];
        `OFS_CLK_TAP:     clk_tap_reg  <= wdata_reg[2:0];
        default:          clk_tap_reg  <= clk_tap_reg;
      endcase
    end
  end

  // Write channel: address and data taken in either order, then response
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_state_reg  <= pinmux_pkg::BUS_IDLE;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      waddr_reg     <= 8'h00;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AXI_OKAY;
    end else begin
      s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready)
                       & (wr_state_reg == pinmux_pkg::BUS_IDLE);
      s_axi_wready  <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready)
                       & (wr_state_reg == pinmux_pkg::BUS_IDLE);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        waddr_reg   <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      case (wr_state_reg)
        pinmux_pkg::BUS_IDLE: begin
          if (wr_fire) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b1;
            s_axi_bresp   <= wr_hit ? `AXI_OKAY : `AXI_SLVERR;
            wr_state_reg  <= pinmux_pkg::BUS_RESP;
          end
        end
        pinmux_pkg::BUS_RESP: begin
          s_axi_awready <= 1'b0;
          s_axi_wready  <= 1'b0;
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= pinmux_pkg::BUS_IDLE;
          end
        end
        default: wr_state_reg <= pinmux_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read decode: raw, masked and enable views give the source in three reads
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_hit   = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFS_IRQ_RAW:     rd_value[IRQ_W-1:0] = irq_src;
      `OFS_IRQ_MASKED:  rd_value[IRQ_W-1:0] = irq_masked;
      `OFS_IRQ_ENABLE:  rd_value[IRQ_W-1:0] = irq_en_reg;
      `OFS_IRQ_EN_SET, `OFS_IRQ_EN_CLR: rd_value = 32'h0000_0000; // Write-only, read as zero
      `OFS_SEL_OUT0:    rd_value[7:0] = sel_reg[0];
      `OFS_SEL_OUT1:    rd_value[7:0] = sel_reg[1];
      `OFS_SEL_OUT2:    rd_value[7:0] = sel_reg[2];
      `OFS_SEL_OUT3:    rd_value[7:0] = sel_reg[3];
      `OFS_CLKREC_CTRL: rd_value[7:0] = sel_reg[4];
      `OFS_GPO:         rd_value[4:0] = gpo_reg;
      `OFS_PROG_IN:     rd_value[2:0] = pin_reg;
      `OFS_IF_MODE:     rd_value[1:0] = if_mode_reg;
      `OFS_CODE_BYP:    rd_value[5:0] = code_byp_reg;
      `OFS_CLK_TAP:     rd_value[2:0] = clk_tap_reg;
      default:          rd_hit = 1'b0;
    endcase
  end

  // Read channel: one outstanding read, answer the cycle after acceptance
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rd_state_reg  <= pinmux_pkg::BUS_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `AXI_OKAY;
    end else begin
      case (rd_state_reg)
        pinmux_pkg::BUS_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_value;
            s_axi_rresp   <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
            rd_state_reg  <= pinmux_pkg::BUS_RESP;
          end
        end
        pinmux_pkg::BUS_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_reg <= pinmux_pkg::BUS_IDLE;
          end
        end
        default: rd_state_reg <= pinmux_pkg::BUS_IDLE;
      endcase
    end
  end

endmodule : irq_and_output_mux

// ### verif/irq_mux_asserts.sv
// Concurrent checks on the interrupt and programmable pin block
module irq_mux_asserts #(
  parameter int IRQ_W         = 16,
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic [IRQ_W-1:0]      irq_src,
  input wire pinmux_pkg::stage_en_s stage_en,
  input wire logic                  irq_req,
  input wire logic                  mac_bypass_on,
  input wire logic                  rf_bypass_on,
  input wire logic                  bypass_rx_data,
  input wire logic                  tx_active,
  input wire logic                  tx_settled
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  // Strobe run length, saturating so a long burst never wraps
  logic [11:0] tx_run;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      tx_run <= 12'h000;
    else if (!tx_active)
      tx_run <= 12'h000;
    else if (tx_run != 12'hfff)
      tx_run <= tx_run + 12'h001;
  end

  // Named steps, each used by one property
  sequence s_tx_both;
    stage_en.tx_if && stage_en.tx_radio_stage;
  endsequence
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_tx_strobe;
    s_tx_both |=> tx_active;
  endproperty
  property p_tx_drop;
    !(stage_en.tx_if && stage_en.tx_radio_stage) |=> !tx_active && !tx_settled;
  endproperty
  property p_settle_early;
    tx_settled |-> tx_active && (tx_run >= SETTLE_CYCLES);
  endproperty
  property p_settle_late;
    tx_active && (tx_run == SETTLE_CYCLES) |-> tx_settled;
  endproperty
  property p_irq_quiet;
    (irq_src == '0) |=> !irq_req;
  endproperty
  property p_mode_excl;
    !(mac_bypass_on && rf_bypass_on);
  endproperty
  property p_rx_bypass;
    bypass_rx_data |-> rf_bypass_on || $past(rf_bypass_on);
  endproperty
  property p_read_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty

  a_tx_strobe: assert property (p_tx_strobe)
    else $error("transmit strobe missing");
  a_tx_drop: assert property (p_tx_drop)
    else $error("transmit strobe late to drop");
  a_settle_early: assert property (p_settle_early)
    else $error("settled flag too early");
  a_settle_late: assert property (p_settle_late)
    else $error("settled flag too late");
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("request without source");
  a_mode_excl: assert property (p_mode_excl)
    else $error("both bypass modes on");
  a_rx_bypass: assert property (p_rx_bypass)
    else $error("receive bypass outside radio bypass");
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
endmodule : irq_mux_asserts

// ### verif/app_proc_model.sv
// Application side model driving the programmable input pins
module app_proc_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] pin_val,
  output logic            prog_in_0,
  output logic            prog_in_1,
  output logic            prog_in_2
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pins move just after an edge, like a processor port
  always_ff @(posedge clk_sys) begin
    prog_in_0 <= pin_val[0];
    prog_in_1 <= pin_val[1];
    prog_in_2 <= pin_val[2];
  end
endmodule : app_proc_model

// ### verif/irq_and_output_mux_tb.sv
// Self-checking bench for the interrupt and programmable pin block
`include "pinmux_cfg.svh"
module irq_and_output_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 8;
  localparam logic [7:0] IRQ_OFS [3] = '{`OFS_SEL_OUT0, `OFS_SEL_OUT1, `OFS_SEL_OUT3};
  localparam int IRQ_PIN [3] = '{0, 1, 3};
  logic clk_sys, arst_n, aw_v, w_v, b_r, ar_v, r_rdy, sleep, wake, mtd, mtc, crd, crk;
  logic aw_r, w_r, b_v, ar_r, r_v, irq_req, mac_on, rf_on, byp_rx, byp_tx, corr_byp;
  logic tx_act, rx_act, tx_set, rx_set;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp;
  logic [15:0] irq_src;
  logic [2:0] pin_val;
  pinmux_pkg::stage_en_s stage_en;
  pinmux_pkg::code_byp_s code_byp;
  wire logic [4:0] po;
  wire logic [2:0] pi;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int cnt;
  logic last;

  irq_and_output_mux #(.SETTLE_CYCLES(SETTLE)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .irq_src(irq_src),
    .sleep(sleep), .stage_en(stage_en), .wakeup_ook_pattern(wake), .mod_tx_data(mtd),
    .mod_tx_clk(mtc), .corr_rx_data(crd), .corr_rx_clk(crk), .prog_in_0(pi[0]),
    .prog_in_1(pi[1]), .prog_in_2(pi[2]), .prog_out_0(po[0]), .prog_out_1(po[1]),
    .prog_out_2(po[2]), .prog_out_3(po[3]), .prog_out_4(po[4]), .irq_req(irq_req),
    .mac_bypass_on(mac_on), .rf_bypass_on(rf_on), .bypass_rx_data(byp_rx),
    .bypass_tx_data(byp_tx), .corr_bypass(corr_byp), .code_byp(code_byp),
    .tx_active(tx_act), .rx_active(rx_act), .tx_settled(tx_set), .rx_settled(rx_set));

  app_proc_model u_app (.clk_sys(clk_sys), .pin_val(pin_val), .prog_in_0(pi[0]),
    .prog_in_1(pi[1]), .prog_in_2(pi[2]));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Wait n edges, then look at settled outputs mid-cycle
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look

  // Address and data offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] bexp = `AXI_OKAY);
    logic ta, tw, got;
    logic [1:0] rs;
    @(posedge clk_sys);
    aw_a <= a;
    aw_v <= 1'b1;
    w_d <= d;
    w_v <= 1'b1;
    b_r <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge clk_sys);
      ta = aw_v && aw_r;
      tw = w_v && w_r;
      got = b_v;
      rs = b_resp;
      @(posedge clk_sys);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
    end
    b_r <= 1'b0;
    chk(rs, bexp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] rexp = `AXI_OKAY);
    logic got;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clk_sys);
    ar_a <= a;
    ar_v <= 1'b1;
    r_rdy <= 1'b1;
    got = 1'b0;
    while (!got) begin
      @(negedge clk_sys);
      got = ar_v && ar_r;
      @(posedge clk_sys);
    end
    ar_v <= 1'b0;
    got = 1'b0;
    while (!got) begin
      @(negedge clk_sys);
      got = r_v;
      d = r_d;
      rs = r_resp;
      @(posedge clk_sys);
    end
    r_rdy <= 1'b0;
    chk(d, exp);
    chk(rs, rexp);
  endtask : rd

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    {aw_v, w_v, b_r, ar_v, r_rdy, sleep, wake, mtd, mtc, crd, crk} = '0;
    {aw_a, ar_a, w_d, irq_src, pin_val} = '0;
    stage_en = '0;
    arst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`OFS_SEL_OUT0, 32'h0);
    rd(8'h3c, 32'h0, `AXI_SLVERR);
    wr(`OFS_IRQ_RAW, 32'hffff, `AXI_SLVERR);
    $display("test reset done");
    wr(`OFS_IRQ_EN_SET, 32'h0005);
    wr(`OFS_IRQ_EN_SET, 32'h0100);
    wr(`OFS_IRQ_EN_CLR, 32'h0001);
    rd(`OFS_IRQ_ENABLE, 32'h0104);
    irq_src <= 16'h0003;
    look(3);
    chk(irq_req, 1'b0);
    rd(`OFS_IRQ_RAW, 32'h0003);
    rd(`OFS_IRQ_MASKED, 32'h0000);
    irq_src <= 16'h0006;
    look(3);
    chk(irq_req, 1'b1);
    rd(`OFS_IRQ_MASKED, 32'h0004);
    irq_src <= 16'h0000;
    $display("test interrupt done");
    wr(`OFS_GPO, 32'h15);
    look(3);
    chk(po, 5'h15);
    @(posedge clk_sys);
    sleep <= 1'b1;
    look(3);
    chk(po, 5'h00);
    @(posedge clk_sys);
    sleep <= 1'b0;
    foreach (IRQ_PIN[i]) begin
      wr(IRQ_OFS[i], 32'h21);
      irq_src <= 16'h0004;
      look(3);
      chk(po[IRQ_PIN[i]], 1'b1);
      @(posedge clk_sys);
      irq_src <= 16'h0000;
      look(3);
      chk(po[IRQ_PIN[i]], 1'b0);
    end
    $display("test general and interrupt pins done");
    @(posedge clk_sys);
    stage_en <= 4'b1100;
    for (int s = 4; s < 8; s++) begin
      wr(`OFS_CLKREC_CTRL, 32'(s));
      look(3);
      chk(po[4], (s == 4) || (s == 7));
    end
    @(posedge clk_sys);
    stage_en <= 4'b1011;
    look(3);
    chk({tx_act, rx_act}, 2'b01);
    @(posedge clk_sys);
    stage_en <= 4'b0000;
    irq_src <= 16'h0004;
    wr(`OFS_CLKREC_CTRL, 32'h0c);
    look(3);
    chk(po[4], 1'b1);
    @(posedge clk_sys);
    stage_en <= 4'b1111;
    look(3);
    chk({tx_set, rx_set}, 2'b00);
    look(SETTLE + 4);
    chk({tx_set, rx_set}, 2'b11);
    @(posedge clk_sys);
    stage_en <= 4'b0000;
    $display("test strobes done");
    wr(`OFS_CLK_TAP, 32'h1);
    wr(`OFS_SEL_OUT3, 32'h02);
    look(3);
    cnt = 0;
    for (int i = 0; i < 16; i++) begin
      last = po[3];
      @(negedge clk_sys);
      cnt += int'(po[3] !== last);
    end
    chk(cnt, 8);
    wr(`OFS_SEL_OUT2, 32'h03);
    wake <= 1'b1;
    look(3);
    chk(po[2], 1'b1);
    $display("test clock and wakeup done");
    wr(`OFS_IF_MODE, 32'h3);
    wr(`OFS_SEL_OUT0, 32'h0a);
    wr(`OFS_SEL_OUT1, 32'h0b);
    {crd, crk} <= 2'b11;
    pin_val <= 3'b110;
    look(8);
    chk({mac_on, rf_on, byp_tx, corr_byp, byp_rx, po[1:0]}, 7'b1011011);
    rd(`OFS_PROG_IN, 32'h6);
    wr(`OFS_IF_MODE, 32'h2);
    wr(`OFS_SEL_OUT0, 32'h08);
    wr(`OFS_SEL_OUT1, 32'h09);
    {mtd, mtc} <= 2'b11;
    pin_val <= 3'b001;
    look(8);
    chk({mac_on, rf_on, byp_tx, byp_rx, po[1:0]}, 6'b010111);
    wr(`OFS_CODE_BYP, 32'h25);
    look(2);
    chk(code_byp, 6'h25);
    rd(`OFS_CODE_BYP, 32'h25);
    $display("test bypass done");
    stop_test();
  end
endmodule : irq_and_output_mux_tb

bind irq_and_output_mux irq_mux_asserts #(.IRQ_W(IRQ_W), .SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .irq_src(irq_src),
  .stage_en(stage_en), .irq_req(irq_req), .mac_bypass_on(mac_bypass_on),
  .rf_bypass_on(rf_bypass_on), .bypass_rx_data(bypass_rx_data), .tx_active(tx_active),
  .tx_settled(tx_settled));
